// file: design/iybcs_sequencer.sv
// bus cycle sequencer for instructions in the indexed-y addressing mode
`timescale 1ns/1ns
module iybcs_sequencer
  import iybcs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // instruction start
  input wire logic start_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] index_y_register_i,
  input wire logic [15:0] stack_ptr_i,
  // opcode class from the outside decoder, valid in cycle two
  input wire iybcs_cls_type op_class_i,
  // write data from the datapath
  input wire logic [7:0] wr_hi_i,
  input wire logic [7:0] wr_lo_i,
  input wire logic [7:0] result_i,
  // memory bus
  input wire logic [7:0] data_i,
  output logic [15:0] addr_o,
  output logic rw_o,
  output logic [7:0] data_o,
  output logic bus_valid_o,
  output logic [3:0] cycle_o,
  // instruction status
  output logic busy_o,
  output logic done_o,
  output logic bad_op_o,
  output logic [15:0] next_pc_o,
  output logic [7:0] offset_o,
  output logic [7:0] opnd_hi_o,
  output logic [7:0] opnd_lo_o,
  output logic [7:0] mask_o,
  output logic [7:0] br_off_o
);

  typedef struct packed {
    iybcs_st_type st;
    logic [3:0] cyc;
    iybcs_cls_type cls;
    logic [15:0] addr;
    logic rw;
    logic [7:0] dout;
    logic [15:0] pc;
    logic [15:0] index_y;
    logic [15:0] sp;
    logic [7:0] offset;
    logic [7:0] opnd_hi;
    logic [7:0] opnd_lo;
    logic [7:0] mask;
    logic [7:0] br_off;
    logic [15:0] next_pc;
    logic done;
    logic bad;
  } iybcs_state_type;

  iybcs_state_type state_r;
  iybcs_state_type state_nxt;

  // number of bus cycles of a class
  function automatic logic [3:0] cls_len(input iybcs_cls_type c);
    case (c)
      IYBCS_CLS_JUMP: cls_len = IYBCS_LEN_JUMP;
      IYBCS_CLS_ALU8: cls_len = IYBCS_LEN_ALU8;
      IYBCS_CLS_RMW: cls_len = IYBCS_LEN_RMW;
      IYBCS_CLS_TEST: cls_len = IYBCS_LEN_TEST;
      IYBCS_CLS_STORE8: cls_len = IYBCS_LEN_STORE8;
      IYBCS_CLS_LOAD16: cls_len = IYBCS_LEN_LOAD16;
      IYBCS_CLS_STORE16: cls_len = IYBCS_LEN_STORE16;
      IYBCS_CLS_ARITH16: cls_len = IYBCS_LEN_ARITH16;
      IYBCS_CLS_CALL: cls_len = IYBCS_LEN_CALL;
      IYBCS_CLS_BITOP: cls_len = IYBCS_LEN_BITOP;
      IYBCS_CLS_BRBIT: cls_len = IYBCS_LEN_BRBIT;
      default: cls_len = IYBCS_LEN_JUMP;
    endcase
  endfunction

  // address source of cycle k (five and up) for a class
  function automatic iybcs_sel_type tail_sel(input iybcs_cls_type c, input logic [3:0] k);
    tail_sel = IYBCS_SEL_ONES;
    case (c)
      IYBCS_CLS_RMW: tail_sel = (k == IYBCS_CYC_SIX) ? IYBCS_SEL_ONES : IYBCS_SEL_EA;
      IYBCS_CLS_TEST: tail_sel = (k == IYBCS_CYC_OPND) ? IYBCS_SEL_EA : IYBCS_SEL_ONES;
      IYBCS_CLS_LOAD16, IYBCS_CLS_STORE16, IYBCS_CLS_ARITH16:
        case (k)
          IYBCS_CYC_OPND: tail_sel = IYBCS_SEL_EA;
          IYBCS_CYC_SIX: tail_sel = IYBCS_SEL_EA1;
          default: tail_sel = IYBCS_SEL_ONES;
        endcase
      IYBCS_CLS_CALL:
        case (k)
          IYBCS_CYC_OPND: tail_sel = IYBCS_SEL_EA;
          IYBCS_CYC_SIX: tail_sel = IYBCS_SEL_SP;
          default: tail_sel = IYBCS_SEL_SP1;
        endcase
      IYBCS_CLS_BITOP:
        case (k)
          IYBCS_CYC_SIX: tail_sel = IYBCS_SEL_PC3;
          IYBCS_CYC_SEVEN: tail_sel = IYBCS_SEL_ONES;
          default: tail_sel = IYBCS_SEL_EA;
        endcase
      IYBCS_CLS_BRBIT:
        case (k)
          IYBCS_CYC_OPND: tail_sel = IYBCS_SEL_EA;
          IYBCS_CYC_SIX: tail_sel = IYBCS_SEL_PC3;
          IYBCS_CYC_SEVEN: tail_sel = IYBCS_SEL_PC4;
          default: tail_sel = IYBCS_SEL_ONES;
        endcase
      default: tail_sel = IYBCS_SEL_EA;
    endcase
  endfunction

  // true when cycle k of a class writes memory
  function automatic logic tail_write(input iybcs_cls_type c, input logic [3:0] k);
    case (c)
      IYBCS_CLS_RMW: tail_write = (k == IYBCS_CYC_SEVEN);
      IYBCS_CLS_STORE8: tail_write = 1'b1;
      IYBCS_CLS_STORE16: tail_write = 1'b1;
      IYBCS_CLS_CALL: tail_write = (k != IYBCS_CYC_OPND);
      IYBCS_CLS_BITOP: tail_write = (k == IYBCS_CYC_EIGHT);
      default: tail_write = 1'b0;
    endcase
  endfunction

  // next-state logic: one step of the bus sequence per clock
  always_comb
  begin
    iybcs_cls_type cls_v;
    iybcs_sel_type sel_v;
    logic [3:0] k_v;
    logic [15:0] ea_v;
    logic [15:0] ret_v;
    cls_v = state_r.cls;
    sel_v = IYBCS_SEL_ONES;
    k_v = state_r.cyc + 4'h1;
    ea_v = state_r.index_y + {8'h00, state_r.offset};
    ret_v = state_r.pc + IYBCS_SIZE_BASIC;
    state_nxt = state_r;
    state_nxt.done = 1'b0;
    state_nxt.bad = 1'b0;
    case (state_r.st)
      IYBCS_ST_IDLE:
      begin
        if (start_i)
        begin
          state_nxt.st = IYBCS_ST_RUN;
          state_nxt.cyc = IYBCS_CYC_PREBYTE;
          state_nxt.pc = pc_i;
          state_nxt.index_y = index_y_register_i;
          state_nxt.sp = stack_ptr_i;
          state_nxt.addr = pc_i;
          state_nxt.rw = 1'b1;
        end
      end
      IYBCS_ST_RUN:
      begin
        // capture what the bus returned in the cycle now ending
        case (state_r.cyc)
          IYBCS_CYC_OPCODE:
          begin
            cls_v = op_class_i;
            state_nxt.cls = op_class_i;
          end
          IYBCS_CYC_OFFSET: state_nxt.offset = data_i;
          IYBCS_CYC_OPND: state_nxt.opnd_hi = data_i;
          IYBCS_CYC_SIX:
          begin
            if (state_r.cls == IYBCS_CLS_BITOP || state_r.cls == IYBCS_CLS_BRBIT)
              state_nxt.mask = data_i;
            else
              state_nxt.opnd_lo = data_i;
          end
          IYBCS_CYC_SEVEN:
          begin
            if (state_r.cls == IYBCS_CLS_BRBIT)
              state_nxt.br_off = data_i;
          end
          default: ;
        endcase
        // head cycles fixed, tail cycles by class
        case (k_v)
          IYBCS_CYC_OPCODE: sel_v = IYBCS_SEL_PC1;
          IYBCS_CYC_OFFSET: sel_v = IYBCS_SEL_PC2;
          IYBCS_CYC_DUMMY: sel_v = IYBCS_SEL_ONES;
          default: sel_v = tail_sel(cls_v, k_v);
        endcase
        case (sel_v)
          IYBCS_SEL_PC1: state_nxt.addr = state_r.pc + 16'h0001;
          IYBCS_SEL_PC2: state_nxt.addr = state_r.pc + 16'h0002;
          IYBCS_SEL_PC3: state_nxt.addr = state_r.pc + 16'h0003;
          IYBCS_SEL_PC4: state_nxt.addr = state_r.pc + 16'h0004;
          IYBCS_SEL_EA: state_nxt.addr = ea_v;
          IYBCS_SEL_EA1: state_nxt.addr = ea_v + 16'h0001;
          IYBCS_SEL_SP: state_nxt.addr = state_r.sp;
          IYBCS_SEL_SP1: state_nxt.addr = state_r.sp - 16'h0001;
          default: state_nxt.addr = IYBCS_ONES_ADDR;
        endcase
        state_nxt.rw = !((k_v >= IYBCS_CYC_OPND) && tail_write(cls_v, k_v));
        // write data is taken at the edge that opens the write cycle
        case (sel_v)
          IYBCS_SEL_SP: state_nxt.dout = ret_v[7:0];
          IYBCS_SEL_SP1: state_nxt.dout = ret_v[15:8];
          IYBCS_SEL_EA1: state_nxt.dout = wr_lo_i;
          default:
          begin
            if (cls_v == IYBCS_CLS_STORE16)
              state_nxt.dout = wr_hi_i;
            else if (cls_v == IYBCS_CLS_STORE8)
              state_nxt.dout = wr_lo_i;
            else
              state_nxt.dout = result_i;
          end
        endcase
        state_nxt.cyc = k_v;
        // a wrong prebyte or unknown class ends the instruction early
        if ((state_r.cyc == IYBCS_CYC_PREBYTE && data_i != IYBCS_PREBYTE) ||
            (state_r.cyc == IYBCS_CYC_OPCODE && cls_len(cls_v) == IYBCS_LEN_JUMP &&
             cls_v != IYBCS_CLS_JUMP))
        begin
          state_nxt.st = IYBCS_ST_IDLE;
          state_nxt.bad = 1'b1;
          state_nxt.cyc = 4'h0;
          state_nxt.addr = IYBCS_ONES_ADDR;
          state_nxt.rw = 1'b1;
        end
        else if (state_r.cyc >= IYBCS_CYC_DUMMY && state_r.cyc == cls_len(cls_v))
        begin
          state_nxt.st = IYBCS_ST_IDLE;
          state_nxt.done = 1'b1;
          state_nxt.cyc = 4'h0;
          state_nxt.addr = IYBCS_ONES_ADDR;
          state_nxt.rw = 1'b1;
          case (cls_v)
            IYBCS_CLS_JUMP, IYBCS_CLS_CALL: state_nxt.next_pc = ea_v;
            IYBCS_CLS_BITOP: state_nxt.next_pc = state_r.pc + IYBCS_SIZE_BITOP;
            IYBCS_CLS_BRBIT: state_nxt.next_pc = state_r.pc + IYBCS_SIZE_BRBIT;
            default: state_nxt.next_pc = ret_v;
          endcase
        end
      end
      default: state_nxt.st = IYBCS_ST_IDLE;
    endcase
  end

  // state register; bus rests at ffffh read while idle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_r <= '0;
      state_r.st <= IYBCS_ST_IDLE;
      state_r.cls <= IYBCS_CLS_BAD;
      state_r.addr <= IYBCS_ONES_ADDR;
      state_r.rw <= 1'b1;
    end
    else
      state_r <= state_nxt;
  end

  // outputs straight from the state register
  assign addr_o = state_r.addr;
  assign rw_o = state_r.rw;
  assign data_o = state_r.dout;
  assign bus_valid_o = (state_r.st == IYBCS_ST_RUN);
  assign cycle_o = state_r.cyc;
  assign busy_o = (state_r.st == IYBCS_ST_RUN);
  assign done_o = state_r.done;
  assign bad_op_o = state_r.bad;
  assign next_pc_o = state_r.next_pc;
  assign offset_o = state_r.offset;
  assign opnd_hi_o = state_r.opnd_hi;
  assign opnd_lo_o = state_r.opnd_lo;
  assign mask_o = state_r.mask;
  assign br_off_o = state_r.br_off;

endmodule // iybcs_sequencer

// file: include/iybcs_pkg.sv
// constants and types for the indexed-y bus cycle sequencer
package iybcs_pkg;

  // fixed bus values
  localparam logic [7:0] IYBCS_PREBYTE = 8'h18;
  localparam logic [15:0] IYBCS_ONES_ADDR = 16'hffff;
  localparam logic [7:0] IYBCS_OP_JUMP = 8'h6e;
  localparam logic [7:0] IYBCS_OP_TEST = 8'h6d;
  localparam logic [7:0] IYBCS_OP_CALL = 8'had;

  // cycle numbers of the common head (cycles 1 to 4) and of the class tail (5 to 8)
  localparam logic [3:0] IYBCS_CYC_PREBYTE = 4'h1;
  localparam logic [3:0] IYBCS_CYC_OPCODE = 4'h2;
  localparam logic [3:0] IYBCS_CYC_OFFSET = 4'h3;
  localparam logic [3:0] IYBCS_CYC_DUMMY = 4'h4;
  localparam logic [3:0] IYBCS_CYC_OPND = 4'h5;
  localparam logic [3:0] IYBCS_CYC_SIX = 4'h6;
  localparam logic [3:0] IYBCS_CYC_SEVEN = 4'h7;
  localparam logic [3:0] IYBCS_CYC_EIGHT = 4'h8;

  // instruction lengths in bus cycles
  localparam logic [3:0] IYBCS_LEN_JUMP = 4'h4;
  localparam logic [3:0] IYBCS_LEN_ALU8 = 4'h5;
  localparam logic [3:0] IYBCS_LEN_RMW = 4'h7;
  localparam logic [3:0] IYBCS_LEN_TEST = 4'h7;
  localparam logic [3:0] IYBCS_LEN_STORE8 = 4'h5;
  localparam logic [3:0] IYBCS_LEN_LOAD16 = 4'h6;
  localparam logic [3:0] IYBCS_LEN_STORE16 = 4'h6;
  localparam logic [3:0] IYBCS_LEN_ARITH16 = 4'h7;
  localparam logic [3:0] IYBCS_LEN_CALL = 4'h7;
  localparam logic [3:0] IYBCS_LEN_BITOP = 4'h8;
  localparam logic [3:0] IYBCS_LEN_BRBIT = 4'h8;

  // instruction byte counts, for the fall-through address
  localparam logic [15:0] IYBCS_SIZE_BASIC = 16'h0003;
  localparam logic [15:0] IYBCS_SIZE_BITOP = 16'h0004;
  localparam logic [15:0] IYBCS_SIZE_BRBIT = 16'h0005;

  // instruction classes, given by the outside opcode decoder
  typedef enum logic [3:0] {
    IYBCS_CLS_JUMP = 4'h0,
    IYBCS_CLS_ALU8 = 4'h1,
    IYBCS_CLS_RMW = 4'h2,
    IYBCS_CLS_TEST = 4'h3,
    IYBCS_CLS_STORE8 = 4'h4,
    IYBCS_CLS_LOAD16 = 4'h5,
    IYBCS_CLS_STORE16 = 4'h6,
    IYBCS_CLS_ARITH16 = 4'h7,
    IYBCS_CLS_CALL = 4'h8,
    IYBCS_CLS_BITOP = 4'h9,
    IYBCS_CLS_BRBIT = 4'ha,
    IYBCS_CLS_BAD = 4'hf
  } iybcs_cls_type;

  // address sources for one bus cycle
  typedef enum logic [3:0] {
    IYBCS_SEL_PC0 = 4'h0,
    IYBCS_SEL_PC1 = 4'h1,
    IYBCS_SEL_PC2 = 4'h2,
    IYBCS_SEL_PC3 = 4'h3,
    IYBCS_SEL_PC4 = 4'h4,
    IYBCS_SEL_ONES = 4'h5,
    IYBCS_SEL_EA = 4'h6,
    IYBCS_SEL_EA1 = 4'h7,
    IYBCS_SEL_SP = 4'h8,
    IYBCS_SEL_SP1 = 4'h9
  } iybcs_sel_type;

  // sequencer states
  typedef enum logic [0:0] {
    IYBCS_ST_IDLE = 1'b0,
    IYBCS_ST_RUN = 1'b1
  } iybcs_st_type;

endpackage

// file: sim/iybcs_memory_model.sv
// behavioural program and data memory on the cpu bus
`timescale 1ns/1ns
module iybcs_memory_model
(
  // clock
  input wire logic clk_i,
  // bus from the sequencer
  input wire logic [15:0] addr_i,
  input wire logic rw_i,
  input wire logic valid_i,
  input wire logic [7:0] wdata_i,
  // read data back
  output logic [7:0] rdata_o
);
  logic [7:0] mem [65536];
  logic [7:0] last_r = 8'h00;
  // idle bus shows the inverse of the last byte, so stale data never matches
  assign rdata_o = (valid_i && rw_i) ? mem[addr_i] : ~last_r;
  // writes land at the edge closing the write cycle
  always @(posedge clk_i)
  begin
    if (valid_i && !rw_i)
      mem[addr_i] <= wdata_i;
    last_r <= rdata_o;
  end
endmodule // iybcs_memory_model

// file: sim/iybcs_properties.sv
// bus cycle assertions for the indexed-y sequencer
`timescale 1ns/1ns
module iybcs_properties
  import iybcs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // start and bus inputs
  input wire logic start_i,
  input wire logic [15:0] pc_i,
  input wire iybcs_cls_type op_class_i,
  input wire logic [7:0] data_i,
  // bus and status outputs
  input wire logic [15:0] addr_o,
  input wire logic rw_o,
  input wire logic bus_valid_o,
  input wire logic [3:0] cycle_o,
  input wire logic busy_o,
  input wire logic done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // cycle two with a given class decoded
  sequence s_head(iybcs_cls_type c);
    cycle_o == IYBCS_CYC_OPCODE && op_class_i == c;
  endsequence
  // two write cycles back to back
  sequence s_two_writes;
    !rw_o [*2];
  endsequence

  property p_start;
    !busy_o && start_i |=> cycle_o == IYBCS_CYC_PREBYTE && addr_o == $past(pc_i) && rw_o;
  endproperty
  a_start: assert property (p_start) else $error("first cycle not at opcode address");
  property p_second;
    cycle_o == IYBCS_CYC_PREBYTE && data_i == IYBCS_PREBYTE |=> cycle_o == IYBCS_CYC_OPCODE
      && addr_o == $past(addr_o) + 16'h0001 && rw_o;
  endproperty
  a_second: assert property (p_second) else $error("second opcode byte misplaced");
  property p_offset;
    cycle_o == IYBCS_CYC_OPCODE && op_class_i <= IYBCS_CLS_BRBIT |=> cycle_o == IYBCS_CYC_OFFSET
      && addr_o == $past(addr_o) + 16'h0001 && rw_o;
  endproperty
  a_offset: assert property (p_offset) else $error("offset fetch misplaced");
  property p_dummy;
    cycle_o == IYBCS_CYC_OFFSET |=> cycle_o == IYBCS_CYC_DUMMY && addr_o == IYBCS_ONES_ADDR && rw_o;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy cycle not an all-ones read");
  property p_jump;
    s_head(IYBCS_CLS_JUMP) |-> ##3 done_o && !bus_valid_o;
  endproperty
  a_jump: assert property (p_jump) else $error("jump length wrong");
  property p_rmw;
    s_head(IYBCS_CLS_RMW) |-> ##3 rw_o ##1 addr_o == IYBCS_ONES_ADDR && rw_o ##1 !rw_o ##1 done_o;
  endproperty
  a_rmw: assert property (p_rmw) else $error("read-modify-write sequence wrong");
  property p_test;
    s_head(IYBCS_CLS_TEST) |=> rw_o [*5] ##1 done_o;
  endproperty
  a_test: assert property (p_test) else $error("memory test wrote or ran long");
  property p_store8;
    s_head(IYBCS_CLS_STORE8) |-> ##3 !rw_o ##1 done_o;
  endproperty
  a_store8: assert property (p_store8) else $error("byte store sequence wrong");
  property p_load16;
    s_head(IYBCS_CLS_LOAD16) |-> ##4 addr_o == $past(addr_o) + 16'h0001 && rw_o ##1 done_o;
  endproperty
  a_load16: assert property (p_load16) else $error("word load sequence wrong");
  property p_call;
    s_head(IYBCS_CLS_CALL) |-> ##3 rw_o ##1 s_two_writes ##1 done_o;
  endproperty
  a_call: assert property (p_call) else $error("call sequence wrong");
  property p_alu8;
    s_head(IYBCS_CLS_ALU8) |-> ##3 rw_o && bus_valid_o ##1 done_o;
  endproperty
  a_alu8: assert property (p_alu8) else $error("byte operand read sequence wrong");
  property p_store16;
    s_head(IYBCS_CLS_STORE16) |-> ##3 s_two_writes ##1 done_o;
  endproperty
  a_store16: assert property (p_store16) else $error("word store sequence wrong");
  property p_arith16;
    s_head(IYBCS_CLS_ARITH16) |-> ##4 rw_o && addr_o == $past(addr_o) + 16'h0001
      ##1 addr_o == IYBCS_ONES_ADDR && rw_o ##1 done_o;
  endproperty
  a_arith16: assert property (p_arith16) else $error("word arithmetic sequence wrong");
  property p_bitop;
    s_head(IYBCS_CLS_BITOP) |-> ##3 rw_o [*2] ##1 addr_o == IYBCS_ONES_ADDR && rw_o ##1 !rw_o ##1 done_o;
  endproperty
  a_bitop: assert property (p_bitop) else $error("bit set or clear sequence wrong");
  property p_brbit;
    s_head(IYBCS_CLS_BRBIT) |=> rw_o [*5] ##1 addr_o == IYBCS_ONES_ADDR && rw_o ##1 done_o;
  endproperty
  a_brbit: assert property (p_brbit) else $error("branch on bits sequence wrong");
endmodule // iybcs_properties

bind iybcs_sequencer iybcs_properties u_props (.clk_i(clk_i), .srst_i(srst_i), .start_i(start_i),
  .pc_i(pc_i), .op_class_i(op_class_i), .data_i(data_i), .addr_o(addr_o), .rw_o(rw_o),
  .bus_valid_o(bus_valid_o), .cycle_o(cycle_o), .busy_o(busy_o), .done_o(done_o));

// file: sim/test_indexed_y_bus_cycle_sequencer.sv
// self-checking bench for the indexed-y bus cycle sequencer
`timescale 1ns/1ns
module test_indexed_y_bus_cycle_sequencer
  import iybcs_pkg::*;
;
  localparam logic [15:0] PC = 16'h1000;
  localparam logic [15:0] EA = 16'h2010;
  localparam logic [15:0] SP = 16'h3000;
  localparam logic [15:0] RET = 16'h1003;
  // class, length, write mask, address codes of cycles 5..8, next address
  typedef struct {iybcs_cls_type cls; logic [3:0] len; logic [3:0] wm;
    logic [15:0] seq; logic [15:0] nxt;} iybcs_row_type;
  iybcs_row_type rows [11] = '{
    '{IYBCS_CLS_JUMP, 4'h4, 4'h0, 16'h0000, EA}, '{IYBCS_CLS_ALU8, 4'h5, 4'h0, 16'h0000, RET},
    '{IYBCS_CLS_RMW, 4'h7, 4'h4, 16'h0020, RET}, '{IYBCS_CLS_TEST, 4'h7, 4'h0, 16'h0220, RET},
    '{IYBCS_CLS_STORE8, 4'h5, 4'h1, 16'h0000, RET}, '{IYBCS_CLS_LOAD16, 4'h6, 4'h0, 16'h0010, RET},
    '{IYBCS_CLS_STORE16, 4'h6, 4'h3, 16'h0010, RET}, '{IYBCS_CLS_ARITH16, 4'h7, 4'h0, 16'h0210, RET},
    '{IYBCS_CLS_CALL, 4'h7, 4'h6, 16'h0650, EA}, '{IYBCS_CLS_BITOP, 4'h8, 4'h8, 16'h0230, 16'h1004},
    '{IYBCS_CLS_BRBIT, 4'h8, 4'h0, 16'h2430, 16'h1005}};
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic start_i = 1'b0;
  logic [15:0] pc_i = PC;
  iybcs_cls_type op_class_i = IYBCS_CLS_ALU8;
  logic [7:0] data_i;
  logic [15:0] addr_o;
  logic rw_o, bus_valid_o, busy_o, done_o, bad_op_o;
  logic [7:0] data_o, offset_o, opnd_hi_o, opnd_lo_o, mask_o, br_off_o;
  logic [3:0] cycle_o;
  logic [15:0] next_pc_o;
  int miscompares = 0;
  int tests_run = 0;

  always #20 clk_i = ~clk_i;

  iybcs_sequencer uut (.clk_i(clk_i), .srst_i(srst_i), .start_i(start_i), .pc_i(pc_i),
    .index_y_register_i(16'h2000), .stack_ptr_i(SP), .op_class_i(op_class_i), .wr_hi_i(8'ha1),
    .wr_lo_i(8'hb2), .result_i(8'hc3), .data_i(data_i), .addr_o(addr_o), .rw_o(rw_o), .data_o(data_o),
    .bus_valid_o(bus_valid_o), .cycle_o(cycle_o), .busy_o(busy_o), .done_o(done_o), .bad_op_o(bad_op_o),
    .next_pc_o(next_pc_o), .offset_o(offset_o), .opnd_hi_o(opnd_hi_o), .opnd_lo_o(opnd_lo_o),
    .mask_o(mask_o), .br_off_o(br_off_o));
  iybcs_memory_model mem_u (.clk_i(clk_i), .addr_i(addr_o), .rw_i(rw_o), .valid_i(bus_valid_o),
    .wdata_i(data_o), .rdata_o(data_i));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // address of one tail cycle from its code
  function automatic logic [15:0] addr_of(input logic [3:0] c);
    case (c)
      4'h0: return EA;
      4'h1: return EA + 16'h0001;
      4'h2: return IYBCS_ONES_ADDR;
      4'h3: return PC + 16'h0003;
      4'h4: return PC + 16'h0004;
      4'h5: return SP;
      default: return SP - 16'h0001;
    endcase
  endfunction

  // byte written in a tail cycle
  function automatic logic [7:0] wdat(input iybcs_cls_type cl, input logic [3:0] c);
    if (c == 4'h5) return RET[7:0];
    if (c == 4'h6) return RET[15:8];
    if (cl == IYBCS_CLS_STORE16 && c == 4'h0) return 8'ha1;
    if (cl == IYBCS_CLS_STORE8 || cl == IYBCS_CLS_STORE16) return 8'hb2;
    return 8'hc3;
  endfunction

  // one instruction, checked cycle by cycle; leaves the bench in the done period
  task run_row(input iybcs_row_type r);
    logic [3:0] c;
    // operand bytes put back, since earlier writes land on them
    mem_u.mem[EA] = 8'h5a;
    mem_u.mem[EA + 16'h0001] = 8'h6b;
    pc_i = PC;
    start_i = 1'b1;
    op_class_i = r.cls;
    @(posedge clk_i);
    #1 start_i = 1'b0;
    for (int k = 1; k <= r.len; k++)
    begin
      check({12'h000, cycle_o}, 16'(k));
      if (k < 5)
      begin
        check(addr_o, (k == 4) ? IYBCS_ONES_ADDR : PC + 16'(k - 1));
        check({15'h0000, rw_o}, 16'h0001);
      end
      else
      begin
        c = r.seq[(k - 5) * 4 +: 4];
        check(addr_o, addr_of(c));
        check({15'h0000, rw_o}, {15'h0000, !r.wm[k - 5]});
        if (!r.wm[k - 5]) ;
        else check({8'h00, data_o}, {8'h00, wdat(r.cls, c)});
      end
      @(posedge clk_i);
      #1;
    end
    check({15'h0000, done_o}, 16'h0001);
    check(next_pc_o, r.nxt);
    check({8'h00, offset_o}, 16'h0010);
    check({14'h0000, busy_o, bus_valid_o}, 16'h0000);
    if (r.len > 4 && !r.wm[0])
      check({8'h00, opnd_hi_o}, 16'h005a);
    if (r.seq[7:4] == 4'h1 && !r.wm[1])
      check({8'h00, opnd_lo_o}, 16'h006b);
    if (r.cls == IYBCS_CLS_BITOP || r.cls == IYBCS_CLS_BRBIT)
      check({8'h00, mask_o}, 16'h003c);
    if (r.cls == IYBCS_CLS_BRBIT)
      check({8'h00, br_off_o}, 16'h004d);
    // the last write of the instruction must have landed in memory
    if (r.len > 4 && r.wm[r.len - 5])
      check({8'h00, mem_u.mem[addr_of(c)]}, {8'h00, wdat(r.cls, c)});
    $display("test of class %h finished", r.cls);
  endtask

  task print_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    mem_u.mem[PC] = IYBCS_PREBYTE;
    mem_u.mem[PC + 16'h0002] = 8'h10;
    mem_u.mem[EA] = 8'h5a;
    mem_u.mem[EA + 16'h0001] = 8'h6b;
    mem_u.mem[PC + 16'h0003] = 8'h3c;
    mem_u.mem[PC + 16'h0004] = 8'h4d;
    mem_u.mem[16'h4000] = 8'h00;
    repeat (2) @(posedge clk_i);
    #1 srst_i = 1'b0;
    check(addr_o, IYBCS_ONES_ADDR);
    check({11'h000, rw_o, cycle_o}, 16'h0010);
    check({13'h0000, busy_o, done_o, bad_op_o}, 16'h0000);
    $display("test of reset finished");
    // rows run back to back, each start after the first taken in the previous done period
    foreach (rows[i])
      run_row(rows[i]);
    // wrong prebyte aborts after cycle one
    pc_i = 16'h4000;
    start_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 start_i = 1'b0;
    check({14'h0000, bad_op_o, bus_valid_o}, 16'h0002);
    $display("test of bad prebyte finished");
    // unknown class aborts after cycle two; start stays high for the next row
    @(posedge clk_i);
    #1 pc_i = PC;
    op_class_i = IYBCS_CLS_BAD;
    start_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    check({14'h0000, bad_op_o, bus_valid_o}, 16'h0002);
    check(addr_o, IYBCS_ONES_ADDR);
    $display("test of bad class finished");
    // reset in mid-instruction returns the bus to idle
    run_row(rows[1]);
    start_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 srst_i = 1'b1;
    start_i = 1'b0;
    @(posedge clk_i);
    #1 srst_i = 1'b0;
    check(addr_o, IYBCS_ONES_ADDR);
    check({11'h000, busy_o, cycle_o}, 16'h0000);
    check(next_pc_o, 16'h0000);
    @(posedge clk_i);
    #1;
    check({11'h000, rw_o, cycle_o}, 16'h0010);
    $display("test of mid-run reset finished");
    print_verdict();
  end
endmodule // test_indexed_y_bus_cycle_sequencer
